// ### hdl/acbn_pkg.sv
// Purpose: Shared constants for the access check and bus error NMI block.
// Assumes: 32-bit addresses, 16 address regions of 256 MB each.
// Notes:   Cause codes and interrupt bit positions are fixed by the core architecture.
package acbn_pkg;

    // Number of access windows on each side.
    localparam int          WIN_MAX          = 8;
    // Window bases and masks work in 64-byte granules.
    localparam int          WIN_GRAN_BITS    = 6;
    // Top address bits that select a region.
    localparam int          REGION_LSB       = 28;
    localparam int          REGION_W         = 4;

    // NMI cause for a store bus error.
    localparam logic [31:0] CAUSE_STORE_NMI  = 32'hf000_0000;
    // NMI cause for a non-blocking load bus error.
    localparam logic [31:0] CAUSE_LOAD_NMI   = 32'hf000_0001;
    // NMI cause reported for a request from outside the core.
    localparam logic [31:0] CAUSE_EXT_NMI    = 32'h0000_0000;

    // Local interrupt causes, highest rank first.
    localparam logic [31:0] CAUSE_EXT_IRQ    = 32'h8000_000b;
    localparam logic [31:0] CAUSE_CE_IRQ     = 32'h8000_001e;
    localparam logic [31:0] CAUSE_TIMER_IRQ  = 32'h8000_0007;

    // Bit positions inside the pending and enable words.
    localparam int          BIT_EXT_IRQ      = 11;
    localparam int          BIT_CE_IRQ       = 30;
    localparam int          BIT_TIMER_IRQ    = 7;

    // Access size code for a word, and how many correctable error sources exist.
    localparam logic [1:0]  SIZE_WORD        = 2'h2;
    localparam int          CE_SRC           = 3;

    // Values after reset.
    localparam logic [31:0] RST_ADDR         = 32'h0000_0000;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;

endpackage : acbn_pkg

// ### hdl/acbn_access_check.sv
// Purpose: Checks fetch and load/store addresses, captures imprecise bus errors, raises NMI
//          and the correctable-error local interrupt.
// Assumes: One clock, synchronous active-high reset, all inputs synchronous to clk_i.
// Notes:   All results are registered; all but the correctable-error interrupt, two cycles after its event, appear one cycle after the request.
`timescale 1ns/10ps
module acbn_access_check #(
    parameter logic [31:0]   IMEM_BASE = 32'hee00_0000,  // Instruction local memory base.
    parameter logic [31:0]   IMEM_SIZE = 32'h0001_0000,  // Instruction local memory bytes.
    parameter logic [31:0]   DMEM_BASE = 32'hf004_0000,  // Data local memory base.
    parameter logic [31:0]   DMEM_SIZE = 32'h0001_0000,  // Data local memory bytes.
    parameter logic [31:0]   IRQC_BASE = 32'hf00c_0000,  // Interrupt controller register base.
    parameter logic [31:0]   IRQC_SIZE = 32'h0000_8000,  // Interrupt controller register bytes.
    parameter logic [7:0]    IWIN_EN   = 8'h00,          // Instruction window enables.
    parameter logic [255:0]  IWIN_BASE = '0,             // Instruction window bases, 32 bits each.
    parameter logic [255:0]  IWIN_MASK = '0,             // Instruction window masks, 32 bits each.
    parameter logic [7:0]    DWIN_EN   = 8'h00,          // Data window enables.
    parameter logic [255:0]  DWIN_BASE = '0,             // Data window bases, 32 bits each.
    parameter logic [255:0]  DWIN_MASK = '0,             // Data window masks, 32 bits each.
    parameter int            CNT_W     = 32              // Correctable error counter width.
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              fetch_req_i,       // Fetch request valid.
    input  wire logic [31:0]       fetch_addr_i,      // First byte of the fetch.
    input  wire logic [1:0]        fetch_len_i,       // Bytes minus one.
    input  wire logic              fetch_spec_i,      // Fetch is speculative.
    input  wire logic              ls_req_i,          // Load/store request valid.
    input  wire logic [31:0]       ls_addr_i,         // First byte of the access.
    input  wire logic [1:0]        ls_size_i,         // 0 byte, 1 half, 2 word.
    input  wire logic              ls_spec_i,         // Access is speculative.
    input  wire logic              wb_err_i,          // Write buffer got a bus error.
    input  wire logic [31:0]       wb_err_addr_i,     // Address of that store.
    input  wire logic              rb_err_i,          // Non-blocking load got a bus error.
    input  wire logic [31:0]       rb_err_addr_i,     // Address of that load.
    input  wire logic              unlock_wr_i,       // Write to the unlock register.
    input  wire logic              ext_nmi_i,         // NMI request from outside the core.
    input  wire logic [2:0]        ce_event_i,        // Correctable errors: cache, instr mem, data mem.
    input  wire logic [2:0]        ce_clr_i,          // Firmware reset of each counter.
    input  wire logic [CNT_W-1:0]  ce_thr_ic_i,       // Threshold of cache counter.
    input  wire logic [CNT_W-1:0]  ce_thr_im_i,       // Threshold of instruction memory counter.
    input  wire logic [CNT_W-1:0]  ce_thr_dm_i,       // Threshold of data memory counter.
    input  wire logic [31:0]       mie_i,             // Interrupt enable word.
    input  wire logic              ext_irq_i,         // External interrupt pending.
    input  wire logic              timer_irq_i,       // Timer interrupt pending.
    output logic                   fetch_fwd_o,       // Fetch goes to the fetch bus.
    output logic                   fetch_local_o,     // Fetch served by local memory.
    output logic                   fetch_fault_o,     // Precise instruction access fault.
    output logic                   ls_fwd_o,          // Access goes to the load/store bus.
    output logic                   ls_local_o,        // Access served locally.
    output logic                   ls_fault_o,        // Precise misaligned or access fault.
    output logic                   nmi_o,             // One-cycle NMI pulse.
    output logic [31:0]            nmi_cause_o,       // Cause of the last NMI.
    output logic [31:0]            err_addr_o,        // First error address capture.
    output logic                   err_lock_o,        // Capture is locked.
    output logic [31:0]            mip_o,             // Interrupt pending word.
    output logic                   irq_o,             // Enabled local interrupt pending.
    output logic [31:0]            irq_cause_o        // Cause of highest ranked interrupt.
);

    // Region number of an address.
    function automatic logic [3:0] region(input logic [31:0] a);
        region = a[acbn_pkg::REGION_LSB +: acbn_pkg::REGION_W];
    endfunction : region

    // True when the address lies in [base, base+size).
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
        in_range = (a >= base) && ((a - base) < size);
    endfunction : in_range

    // True when the address hits any enabled window; the base is 64-byte aligned.
    function automatic logic win_hit(input logic [31:0] a, input logic [7:0] en,
                                     input logic [255:0] bases, input logic [255:0] masks);
        logic [31:0] b;
        logic [31:0] m;
        win_hit = 1'b0;
        for (int i = 0; i < acbn_pkg::WIN_MAX; i++)
        begin
            b = bases[i*32 +: 32];
            m = masks[i*32 +: 32] | 32'h0000_003f;
            b[acbn_pkg::WIN_GRAN_BITS-1:0] = '0;
            if (en[i] && ((a & ~m) == b))
            begin
                win_hit = 1'b1;
            end
        end
    endfunction : win_hit

    // Whether any window is enabled on each side.
    logic        iwin_on;   // Instruction protection active.
    logic        dwin_on;   // Data protection active.
    assign iwin_on = |IWIN_EN;
    assign dwin_on = |DWIN_EN;

    // Last byte of each access.
    logic [31:0] f_end;     // Last fetched byte.
    logic [31:0] d_end;     // Last accessed data byte.
    logic [31:0] d_len;     // Data bytes minus one.
    assign f_end = fetch_addr_i + {30'h0, fetch_len_i};
    assign d_len = (32'h1 << ls_size_i) - 32'h1;
    assign d_end = ls_addr_i + d_len;

    // Fetch classification terms.
    logic        f_lregion; // Either end sits in the instruction memory region.
    logic        f_inmem;   // Whole fetch inside instruction memory.
    logic        f_hit;     // Whole fetch inside enabled windows.
    assign f_lregion = (region(fetch_addr_i) == region(IMEM_BASE)) || (region(f_end) == region(IMEM_BASE));
    assign f_inmem   = in_range(fetch_addr_i, IMEM_BASE, IMEM_SIZE) && in_range(f_end, IMEM_BASE, IMEM_SIZE);
    assign f_hit     = win_hit(fetch_addr_i, IWIN_EN, IWIN_BASE, IWIN_MASK)
                       && win_hit(f_end, IWIN_EN, IWIN_BASE, IWIN_MASK);

    // Data classification terms.
    logic        d_lregion; // Either end in the data memory or register block region.
    logic        d_indccm;  // Whole access inside data memory.
    logic        d_inpic;   // Whole access inside the register block.
    logic        d_picok;   // Register block access is an aligned word.
    logic        d_hit;     // Whole access inside enabled windows.
    assign d_lregion = (region(ls_addr_i) == region(DMEM_BASE)) || (region(d_end) == region(DMEM_BASE))
                       || (region(ls_addr_i) == region(IRQC_BASE)) || (region(d_end) == region(IRQC_BASE));
    assign d_indccm  = in_range(ls_addr_i, DMEM_BASE, DMEM_SIZE) && in_range(d_end, DMEM_BASE, DMEM_SIZE);
    assign d_inpic   = in_range(ls_addr_i, IRQC_BASE, IRQC_SIZE) && in_range(d_end, IRQC_BASE, IRQC_SIZE);
    assign d_picok   = (ls_size_i == acbn_pkg::SIZE_WORD) && (ls_addr_i[1:0] == 2'h0);
    assign d_hit     = win_hit(ls_addr_i, DWIN_EN, DWIN_BASE, DWIN_MASK)
                       && win_hit(d_end, DWIN_EN, DWIN_BASE, DWIN_MASK);

    // Fetch decision, registered one cycle after the request.
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !fetch_req_i)
        begin
            fetch_fwd_o   <= 1'b0;
            fetch_local_o <= 1'b0;
            fetch_fault_o <= 1'b0;
        end
        else if (f_lregion)
        begin
            // Inside the local region the whole fetch must be in memory.
            fetch_fwd_o   <= 1'b0;
            fetch_local_o <= f_inmem;
            fetch_fault_o <= !f_inmem;
        end
        else
        begin
            // Elsewhere the windows decide; speculative misses are dropped silently.
            fetch_fwd_o   <= !iwin_on || f_hit;
            fetch_local_o <= 1'b0;
            fetch_fault_o <= iwin_on && !f_hit && !fetch_spec_i;
        end
    end

    // Load/store decision, registered one cycle after the request.
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !ls_req_i)
        begin
            ls_fwd_o   <= 1'b0;
            ls_local_o <= 1'b0;
            ls_fault_o <= 1'b0;
        end
        else if (d_lregion)
        begin
            // Local region: stay inside one sub-region; registers take aligned words only.
            ls_fwd_o   <= 1'b0;
            ls_local_o <= d_indccm || (d_inpic && d_picok);
            ls_fault_o <= !(d_indccm || (d_inpic && d_picok));
        end
        else
        begin
            ls_fwd_o   <= !dwin_on || d_hit;
            ls_local_o <= 1'b0;
            ls_fault_o <= dwin_on && !d_hit && !ls_spec_i;
        end
    end

    // A bus error is taken only while the capture is open; an unlock in the same cycle opens it.
    logic        cap_open;  // Capture may take a new error this cycle.
    logic        bus_err;   // A bus error is taken this cycle.
    assign cap_open = !err_lock_o || unlock_wr_i;
    assign bus_err  = cap_open && (rb_err_i || wb_err_i);

    // First error capture and its lock.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            err_lock_o <= 1'b0;
            err_addr_o <= acbn_pkg::RST_ADDR;
        end
        else if (bus_err)
        begin
            // A new error wins over an unlock in the same cycle.
            err_lock_o <= 1'b1;
            err_addr_o <= rb_err_i ? rb_err_addr_i : wb_err_addr_i;
        end
        else if (unlock_wr_i)
        begin
            err_lock_o <= 1'b0;
        end
    end

    // NMI pulse and cause; bus error causes take precedence over an external request.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            nmi_o       <= 1'b0;
            nmi_cause_o <= acbn_pkg::RST_WORD;
        end
        else
        begin
            nmi_o <= bus_err || ext_nmi_i;
            if (bus_err && rb_err_i)
            begin
                nmi_cause_o <= acbn_pkg::CAUSE_LOAD_NMI;
            end
            else if (bus_err)
            begin
                nmi_cause_o <= acbn_pkg::CAUSE_STORE_NMI;
            end
            else if (ext_nmi_i)
            begin
                nmi_cause_o <= acbn_pkg::CAUSE_EXT_NMI;
            end
        end
    end

    // Correctable error counters; an event in the clearing cycle counts as one.
    logic [CNT_W-1:0] ce_cnt [acbn_pkg::CE_SRC];   // Error counts.
    logic [CNT_W-1:0] ce_thr [acbn_pkg::CE_SRC];   // Thresholds per counter.
    logic [2:0]       ce_reach;                    // Counter has reached its threshold.
    assign ce_thr[0] = ce_thr_ic_i;
    assign ce_thr[1] = ce_thr_im_i;
    assign ce_thr[2] = ce_thr_dm_i;

    always_ff @(posedge clk_i)
    begin
        for (int k = 0; k < acbn_pkg::CE_SRC; k++)
        begin
            if (reset_i)
            begin
                ce_cnt[k] <= '0;
            end
            else if (ce_clr_i[k])
            begin
                ce_cnt[k] <= {{(CNT_W-1){1'b0}}, ce_event_i[k]};
            end
            else if (ce_event_i[k] && (ce_cnt[k] != {CNT_W{1'b1}}))
            begin
                ce_cnt[k] <= ce_cnt[k] + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_comb
    begin
        for (int k = 0; k < acbn_pkg::CE_SRC; k++)
        begin
            ce_reach[k] = ce_cnt[k] >= ce_thr[k];
        end
    end

    // Pending word and ranked local interrupt: external, then correctable error, then timer.
    logic [31:0] next_mip;      // Pending word for the next cycle.
    logic [31:0] act;           // Pending and enabled.
    always_comb
    begin
        next_mip = '0;
        next_mip[acbn_pkg::BIT_EXT_IRQ]   = ext_irq_i;
        next_mip[acbn_pkg::BIT_CE_IRQ]    = |ce_reach;
        next_mip[acbn_pkg::BIT_TIMER_IRQ] = timer_irq_i;
        act = next_mip & mie_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            mip_o       <= acbn_pkg::RST_WORD;
            irq_o       <= 1'b0;
            irq_cause_o <= acbn_pkg::RST_WORD;
        end
        else
        begin
            mip_o <= next_mip;
            irq_o <= |act;
            if (act[acbn_pkg::BIT_EXT_IRQ])
            begin
                irq_cause_o <= acbn_pkg::CAUSE_EXT_IRQ;
            end
            else if (act[acbn_pkg::BIT_CE_IRQ])
            begin
                irq_cause_o <= acbn_pkg::CAUSE_CE_IRQ;
            end
            else if (act[acbn_pkg::BIT_TIMER_IRQ])
            begin
                irq_cause_o <= acbn_pkg::CAUSE_TIMER_IRQ;
            end
        end
    end

    // Checks on the behaviour above.
    a_load_first_wins: assert property (@(posedge clk_i) disable iff (reset_i)
        (!err_lock_o && rb_err_i) |=> (nmi_o && err_lock_o && nmi_cause_o == acbn_pkg::CAUSE_LOAD_NMI
                                       && err_addr_o == $past(rb_err_addr_i)))
        else $error("First load bus error not captured with its cause.");

    a_store_cause_code: assert property (@(posedge clk_i) disable iff (reset_i)
        (!err_lock_o && wb_err_i && !rb_err_i) |=> (nmi_cause_o == acbn_pkg::CAUSE_STORE_NMI
                                                    && err_addr_o == $past(wb_err_addr_i)))
        else $error("First store bus error not captured with its cause.");

    a_locked_gates_nmi: assert property (@(posedge clk_i) disable iff (reset_i)
        (err_lock_o && !unlock_wr_i && !ext_nmi_i) |=> !nmi_o)
        else $error("Bus error raised an NMI while the capture was locked.");

    a_lock_holds_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        (err_lock_o && !unlock_wr_i) |=> (err_lock_o && $stable(err_addr_o)))
        else $error("Locked capture changed without an unlock.");

    a_ext_nmi_honored: assert property (@(posedge clk_i) disable iff (reset_i)
        ext_nmi_i |=> nmi_o)
        else $error("External NMI request was dropped.");

    a_fetch_local_fault: assert property (@(posedge clk_i) disable iff (reset_i)
        (fetch_req_i && f_lregion && !f_inmem) |=> (fetch_fault_o && !fetch_fwd_o))
        else $error("Fetch outside local memory in its region did not fault.");

    a_fetch_win_miss: assert property (@(posedge clk_i) disable iff (reset_i)
        (fetch_req_i && !f_lregion) |=> (fetch_fwd_o == (!iwin_on || $past(f_hit))))
        else $error("Fetch forward decision disagrees with the windows.");

    a_data_win_miss: assert property (@(posedge clk_i) disable iff (reset_i)
        (ls_req_i && !d_lregion && !ls_spec_i) |=> (ls_fault_o == (dwin_on && !$past(d_hit))))
        else $error("Load/store fault decision disagrees with the windows.");

    a_regs_word_only: assert property (@(posedge clk_i) disable iff (reset_i)
        (ls_req_i && d_inpic && !d_indccm && !d_picok) |=> ls_fault_o)
        else $error("Unaligned or sub-word register block access did not fault.");

    a_ce_pending_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        (|ce_reach) |=> mip_o[acbn_pkg::BIT_CE_IRQ])
        else $error("Counter at threshold did not set the pending bit.");

endmodule : acbn_access_check

// ### dv/acbn_bus_model.sv
// Purpose: System bus model that answers stores and loads and flags unmapped ones.
// Assumes: Region 9 of the address map has no slave behind it.
// Notes:   An error pulse comes one cycle after the request.
`timescale 1ns/10ps
module acbn_bus_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        st_req_i,      // Store issued onto the bus.
    input  wire logic [31:0] st_addr_i,     // Store address.
    input  wire logic        ld_req_i,      // Non-blocking load issued.
    input  wire logic [31:0] ld_addr_i,     // Load address.
    output logic             wb_err_o,      // Store error response.
    output logic [31:0]      wb_err_addr_o, // Address of the failed store.
    output logic             rb_err_o,      // Load error response.
    output logic [31:0]      rb_err_addr_o  // Address of the failed load.
);
    // Answers each request one cycle later; an idle address line shows the inverse of its last value.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wb_err_o      <= 1'b0;
            rb_err_o      <= 1'b0;
            wb_err_addr_o <= 32'h0000_0000;
            rb_err_addr_o <= 32'h0000_0000;
        end
        else
        begin
            wb_err_o      <= st_req_i && (st_addr_i[31:28] == 4'h9);
            rb_err_o      <= ld_req_i && (ld_addr_i[31:28] == 4'h9);
            wb_err_addr_o <= st_req_i ? st_addr_i : ~wb_err_addr_o;
            rb_err_addr_o <= ld_req_i ? ld_addr_i : ~rb_err_addr_o;
        end
    end
endmodule : acbn_bus_model

// ### dv/acbn_access_check_tb.sv
// Purpose: Self-checking bench for the access check and bus error NMI block.
// Assumes: One instruction window at 2000_0000 and one data window at 3000_0000.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module acbn_access_check_tb;
    logic clk_i = 1'b0, reset_i = 1'b1, f_req = 1'b0, f_spec = 1'b0, l_req = 1'b0, l_spec = 1'b0;
    logic st_req = 1'b0, ld_req = 1'b0, wb_err, rb_err, unlock = 1'b0, xnmi = 1'b0, xirq = 1'b0, tirq = 1'b0;
    logic [31:0] f_addr = '0, l_addr = '0, st_addr = '0, ld_addr = '0, wb_a, rb_a, nmi_cause, err_addr, mip, icause;
    logic [1:0]  f_len = '0, l_size = '0;
    logic [2:0]  ce_ev = '0, ce_clr = '0;
    logic [31:0] mie = 32'h4000_0880;
    logic [7:0]  thr_ic = 8'h02, thr_im = 8'h05, thr_dm = 8'h05;
    logic        f_fwd, f_loc, f_flt, l_fwd, l_loc, l_flt, nmi, lock, irq;
    int          err_count = 0, tests_run = 0, cycles = 0;
    // The clock toggles every half period of 10 ns.
    always #10 clk_i = ~clk_i;
    acbn_bus_model BUS (.clk_i(clk_i), .reset_i(reset_i), .st_req_i(st_req), .st_addr_i(st_addr),
        .ld_req_i(ld_req), .ld_addr_i(ld_addr), .wb_err_o(wb_err), .wb_err_addr_o(wb_a),
        .rb_err_o(rb_err), .rb_err_addr_o(rb_a));
    acbn_access_check #(.IWIN_EN(8'h01), .IWIN_BASE({224'h0, 32'h2000_0000}), .IWIN_MASK({224'h0, 32'h0000_ffff}),
        .DWIN_EN(8'h02), .DWIN_BASE({192'h0, 32'h3000_0000, 32'h0}),
        .DWIN_MASK({192'h0, 32'h0000_0fff, 32'h0}), .CNT_W(8)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .fetch_req_i(f_req), .fetch_addr_i(f_addr), .fetch_len_i(f_len),
        .fetch_spec_i(f_spec), .ls_req_i(l_req), .ls_addr_i(l_addr), .ls_size_i(l_size), .ls_spec_i(l_spec),
        .wb_err_i(wb_err), .wb_err_addr_i(wb_a), .rb_err_i(rb_err), .rb_err_addr_i(rb_a), .unlock_wr_i(unlock),
        .ext_nmi_i(xnmi), .ce_event_i(ce_ev), .ce_clr_i(ce_clr), .ce_thr_ic_i(thr_ic), .ce_thr_im_i(thr_im),
        .ce_thr_dm_i(thr_dm), .mie_i(mie), .ext_irq_i(xirq), .timer_irq_i(tirq), .fetch_fwd_o(f_fwd),
        .fetch_local_o(f_loc), .fetch_fault_o(f_flt), .ls_fwd_o(l_fwd), .ls_local_o(l_loc), .ls_fault_o(l_flt),
        .nmi_o(nmi), .nmi_cause_o(nmi_cause), .err_addr_o(err_addr), .err_lock_o(lock), .mip_o(mip),
        .irq_o(irq), .irq_cause_o(icause));
    // Moves to just after the next rising edge.
    task step;
        @(posedge clk_i);
        #1;
    endtask : step
    // Compares one result and counts it.
    task chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One fetch; expected outputs as fwd, local, fault.
    task fetch(input logic [31:0] a, input logic [1:0] n, input logic s, input logic [2:0] e);
        f_req = 1'b1; f_addr = a; f_len = n; f_spec = s;
        step();
        f_req = 1'b0;
        chk({29'h0, f_fwd, f_loc, f_flt}, {29'h0, e});
        step();
    endtask : fetch
    // One load or store check; expected outputs as fwd, local, fault.
    task ls(input logic [31:0] a, input logic [1:0] z, input logic s, input logic [2:0] e);
        l_req = 1'b1; l_addr = a; l_size = z; l_spec = s;
        step();
        l_req = 1'b0;
        chk({29'h0, l_fwd, l_loc, l_flt}, {29'h0, e});
        step();
    endtask : ls
    // Issues bus traffic and waits until the capture answer is due.
    task bus(input logic s, input logic [31:0] sa, input logic l, input logic [31:0] la);
        st_req = s; st_addr = sa; ld_req = l; ld_addr = la;
        step();
        st_req = 1'b0; ld_req = 1'b0;
        step();
    endtask : bus
    // Prints the counts and the verdict, then stops.
    task final_report;
        $display("Checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Cuts a hang short.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            final_report();
        end
    end
    // Main sequence.
    initial
    begin
        repeat (5) @(posedge clk_i);
        #1 reset_i = 1'b0;
        chk(err_addr, 32'h0);
        fetch(32'hee00_0000, 2'h3, 1'b0, 3'b010);
        fetch(32'hee00_fffe, 2'h3, 1'b0, 3'b001);
        fetch(32'hee10_0000, 2'h1, 1'b1, 3'b001);
        fetch(32'h2000_0100, 2'h3, 1'b0, 3'b100);
        fetch(32'h2000_fffe, 2'h3, 1'b0, 3'b001);
        fetch(32'h4000_0000, 2'h3, 1'b0, 3'b001);
        fetch(32'h4000_0000, 2'h3, 1'b1, 3'b000);
        ls(32'hf004_0000, 2'h2, 1'b0, 3'b010);
        ls(32'hf004_fffe, 2'h2, 1'b0, 3'b001);
        ls(32'hf000_0000, 2'h0, 1'b0, 3'b001);
        ls(32'hf00c_0000, 2'h2, 1'b0, 3'b010);
        ls(32'hf00c_0000, 2'h1, 1'b0, 3'b001);
        ls(32'hf00c_0002, 2'h2, 1'b0, 3'b001);
        ls(32'h3000_0ffc, 2'h2, 1'b0, 3'b100);
        ls(32'h3000_0ffe, 2'h2, 1'b0, 3'b001);
        ls(32'h5000_0000, 2'h0, 1'b0, 3'b001);
        ls(32'h5000_0000, 2'h0, 1'b1, 3'b000);
        bus(1'b1, 32'h9000_0010, 1'b0, 32'h0);
        chk({nmi, lock}, 2'b11);
        chk(nmi_cause, 32'hf000_0000);
        chk(err_addr, 32'h9000_0010);
        bus(1'b1, 32'h9000_0020, 1'b0, 32'h0);
        chk({nmi, lock}, 2'b01);
        bus(1'b0, 32'h0, 1'b1, 32'h9000_0030);
        chk({nmi, lock}, 2'b01);
        chk(err_addr, 32'h9000_0010);
        xnmi = 1'b1;
        step();
        xnmi = 1'b0;
        chk({nmi, nmi_cause}, 33'h1_0000_0000);
        unlock = 1'b1;
        step();
        unlock = 1'b0;
        chk(lock, 1'b0);
        bus(1'b1, 32'h9000_0100, 1'b1, 32'h9000_0200);
        chk({nmi, lock}, 2'b11);
        chk(nmi_cause, 32'hf000_0001);
        chk(err_addr, 32'h9000_0200);
        reset_i = 1'b1;
        step();
        step();
        reset_i = 1'b0;
        chk({lock, err_addr}, 33'h0);
        ce_ev = 3'h1;
        step();
        step();
        ce_ev = 3'h0;
        chk(mip[30], 1'b0);
        step();
        chk({irq, mip[30], icause}, {2'b11, 32'h8000_001e});
        xirq = 1'b1;
        repeat (3) step();
        chk(icause, 32'h8000_000b);
        chk(mip, 32'h4000_0800);
        xirq = 1'b0; tirq = 1'b1; ce_clr = 3'h1;
        step();
        ce_clr = 3'h0;
        repeat (3) step();
        chk({mip[30], icause}, {1'b0, 32'h8000_0007});
        chk(mip, 32'h0000_0080);
        // Data memory counter reaches a threshold of one while only the external enable is set.
        mie = 32'h0000_0800; thr_dm = 8'h01; ce_ev = 3'h4;
        step();
        ce_ev = 3'h0;
        step();
        chk({irq, mip}, {1'b0, 32'h4000_0080});
        chk(icause, 32'h8000_0007);
        final_report();
    end
endmodule : acbn_access_check_tb
